// File: amp_params.svh
// Register offsets, reset values and timing counts for the amplifier control block
`ifndef AMP_PARAMS_SVH
`define AMP_PARAMS_SVH

// Register byte offsets
`define AMP_REG_CTRL 8'h00
`define AMP_REG_STATUS 8'h04
`define AMP_REG_IRQ_STAT 8'h08
`define AMP_REG_IRQ_MASK 8'h0c

// Control register fields
`define AMP_CTRL_SW_MUTE 0
`define AMP_CTRL_GAIN_OVR 1
`define AMP_CTRL_GAIN_LSB 2
`define AMP_CTRL_GAIN_MSB 3

// Reset values
`define AMP_CTRL_RESET 4'h0
`define AMP_IRQ_MASK_RESET 6'h00

// Interrupt status bit positions
`define AMP_IRQ_WARN 0
`define AMP_IRQ_OVERTEMP 1
`define AMP_IRQ_OVERCURRENT 2
`define AMP_IRQ_UNDERVOLT 3
`define AMP_IRQ_CLK_LOSS 4
`define AMP_IRQ_CLEARED 5
`define AMP_IRQ_W 6

// Fault cause bit positions
`define AMP_CAUSE_OT 0
`define AMP_CAUSE_OC 1
`define AMP_CAUSE_UV 2
`define AMP_CAUSE_CL 3

// Timing: pclk runs at 125 MHz
`define AMP_PCLK_MHZ 125
`define AMP_CLK_LOSS_NS 1000
`define AMP_CLK_LOSS_CYC ((`AMP_CLK_LOSS_NS * `AMP_PCLK_MHZ) / 1000)
`define AMP_SOFT_STEP_NS 1000
`define AMP_SOFT_STEP_CYC ((`AMP_SOFT_STEP_NS * `AMP_PCLK_MHZ) / 1000)

// Master clock is the external clock divided by this
`define AMP_MCLK_DIV 2

`endif

// File: amp_pkg.sv
// Types shared by the amplifier control block
package amp_pkg;

   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_MUTED = 2'b01,
      ST_RAMP = 2'b10,
      ST_RUN = 2'b11
   } stage_e;

   // Analog comparator results, synchronous to pclk
   typedef struct packed {
      logic temp_warn;
      logic temp_over;
      logic over_current;
      logic pvdd_low;
   } sense_s;

   typedef struct packed {
      logic pos;
      logic neg;
   } diff_s;

   // Input gain in dB for a gain-select code
   function automatic logic [4:0] gain_db_f(input logic [1:0] code);
      case (code)
         2'b00: gain_db_f = 5'h00;
         2'b01: gain_db_f = 5'h06;
         2'b10: gain_db_f = 5'h0c;
         2'b11: gain_db_f = 5'h12;
         default: gain_db_f = 5'h00;
      endcase
   endfunction

endpackage

// File: pdm_channel.sv
// One-bit two-level sigma-delta modulator for one channel, differential output
`timescale 1ns/1ps
`default_nettype none

module pdm_channel (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Control
   input wire logic step,
   input wire logic run,
   input wire logic [1:0] gain_code,
   input wire logic [7:0] level,
   // Audio
   input wire logic signed [15:0] sample,
   // Stream
   output amp_pkg::diff_s out
);
   import amp_pkg::*;

   logic signed [19:0] gained;
   logic signed [28:0] prod;
   logic signed [19:0] scaled;
   logic signed [21:0] acc_q;
   logic signed [21:0] fb;
   logic bit_q;

   // Each gain step is 6 dB, a doubling
   assign gained = $signed({{4{sample[15]}}, sample}) <<< gain_code;
   assign prod = $signed(gained) * $signed({1'b0, level});
   assign scaled = prod[27:8];
   assign fb = bit_q ? 22'sh0c0000 : -22'sh0c0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q <= 22'sh000000;
         bit_q <= 1'b0;
      end else if (ce && step) begin
         if (!run) begin
            acc_q <= 22'sh000000;
            bit_q <= 1'b0;
         end else begin
            acc_q <= acc_q + {{2{scaled[19]}}, scaled} - fb;
            bit_q <= (acc_q >= 0);
         end
      end
   end

   // Opposite legs of the bridge, both low from the first step while idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out <= '0;
      end else if (ce && step) begin
         out.pos <= run & bit_q;
         out.neg <= run & ~bit_q;
      end
   end

endmodule

`default_nettype wire

// File: amp_fault_gain_control.sv
// Control and protection logic of a two-channel switching amplifier
`timescale 1ns/1ps
`default_nettype none
`include "amp_params.svh"

module amp_fault_gain_control (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Control pins
   input wire logic mute_n,
   input wire logic power_down_n,
   input wire logic gain_select_msb,
   input wire logic gain_select_lsb,
   input wire logic ext_clock_in,
   // Sensors and audio
   input wire amp_pkg::sense_s sense,
   input wire logic signed [15:0] sample_left,
   input wire logic signed [15:0] sample_right,
   // Open-drain flags
   output logic fault_n_o,
   output logic fault_n_oe,
   output logic thermal_warning_n_o,
   output logic thermal_warning_n_oe,
   // Power stage
   output logic master_clk,
   output logic stage_enable,
   output logic stage_hiz,
   output logic [4:0] gain_db,
   output logic [7:0] soft_level,
   output amp_pkg::diff_s out_left,
   output amp_pkg::diff_s out_right,
   // Interrupt
   output logic irq
);
   import amp_pkg::*;

   localparam logic [7:0] LOSS_CYC = 8'(`AMP_CLK_LOSS_CYC);
   localparam logic [7:0] STEP_CYC = 8'(`AMP_SOFT_STEP_CYC);

   logic ext_q;
   logic ext_prev_q;
   logic ext_rise;
   logic mclk_q;
   logic mclk_tick;
   logic [7:0] loss_cnt_q;
   logic clk_lost;
   logic mute_m1_q;
   logic mute_s_q;
   logic pd_m1_q;
   logic pd_s_q;
   logic mute_seen_q;
   logic clear_evt;
   sense_s sense_q;
   logic [3:0] cause_q;
   logic [3:0] cause_d;
   logic warn_prev_q;
   stage_e state_q;
   stage_e state_d;
   logic [7:0] level_q;
   logic [7:0] step_cnt_q;
   logic [3:0] ctrl_q;
   logic [5:0] irq_stat_q;
   logic [5:0] irq_mask_q;
   logic [5:0] irq_ev;
   logic [1:0] gain_code;
   logic access;
   logic done;
   logic rd_stat;
   logic mapped;
   logic [31:0] rd_mux;
   logic run;

   // External clock: one sample, the pin is taken as synchronous
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end else if (ce) begin
         ext_q <= ext_clock_in;
         ext_prev_q <= ext_q;
      end
   end

   assign ext_rise = ext_q & ~ext_prev_q;
   // Master clock rises on every second external rising edge
   assign mclk_tick = ext_rise & ~mclk_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mclk_q <= 1'b0;
      end else if (ce && ext_rise) begin
         mclk_q <= ~mclk_q;
      end
   end

   assign master_clk = mclk_q;

   // Clock-loss watchdog, saturates so it never wraps back to healthy
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loss_cnt_q <= 8'h00;
      end else if (ce) begin
         if (ext_rise) begin
            loss_cnt_q <= 8'h00;
         end else if (loss_cnt_q != LOSS_CYC) begin
            loss_cnt_q <= loss_cnt_q + 8'h01;
         end
      end
   end

   assign clk_lost = (loss_cnt_q == LOSS_CYC);

   // Mute and power-down pins re-timed on master clock ticks; a dead clock freezes them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mute_m1_q <= 1'b0;
         mute_s_q <= 1'b0;
         pd_m1_q <= 1'b0;
         pd_s_q <= 1'b0;
      end else if (ce && mclk_tick) begin
         mute_m1_q <= mute_n;
         mute_s_q <= mute_m1_q;
         pd_m1_q <= power_down_n;
         pd_s_q <= pd_m1_q;
      end
   end

   // Low-then-high on mute arms and fires the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mute_seen_q <= 1'b0;
      end else if (ce) begin
         if (!mute_s_q) begin
            mute_seen_q <= 1'b1;
         end else if (mute_seen_q) begin
            mute_seen_q <= 1'b0;
         end
      end
   end

   assign clear_evt = mute_s_q & mute_seen_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sense_q <= '0;
      end else if (ce) begin
         sense_q <= sense;
      end
   end

   // Latched causes: a fault present during the clear survives it
   always_comb begin
      cause_d = cause_q;
      if (clear_evt || !pd_s_q) begin
         cause_d = 4'h0;
      end
      if (pd_s_q) begin
         if (sense_q.temp_over) begin
            cause_d[`AMP_CAUSE_OT] = 1'b1;
         end
         if (sense_q.over_current) begin
            cause_d[`AMP_CAUSE_OC] = 1'b1;
         end
         if (sense_q.pvdd_low) begin
            cause_d[`AMP_CAUSE_UV] = 1'b1;
         end
         if (clk_lost) begin
            cause_d[`AMP_CAUSE_CL] = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cause_q <= 4'h0;
      end else if (ce) begin
         cause_q <= cause_d;
      end
   end

   // Open-drain flags: data always low, enable pulls the wire
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_n_o <= 1'b0;
         fault_n_oe <= 1'b0;
         thermal_warning_n_o <= 1'b0;
         thermal_warning_n_oe <= 1'b0;
         warn_prev_q <= 1'b0;
      end else if (ce) begin
         fault_n_o <= 1'b0;
         fault_n_oe <= |cause_d;
         thermal_warning_n_o <= 1'b0;
         thermal_warning_n_oe <= sense_q.temp_warn & pd_s_q;
         warn_prev_q <= sense_q.temp_warn & pd_s_q;
      end
   end

   // Stage sequencing; the warning is deliberately absent here
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_OFF: begin
            if (pd_s_q) begin
               state_d = ST_MUTED;
            end
         end
         ST_MUTED: begin
            if (mute_s_q && !(|cause_d) && !ctrl_q[`AMP_CTRL_SW_MUTE]) begin
               state_d = ST_RAMP;
            end
         end
         ST_RAMP: begin
            if (level_q == 8'hff) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            state_d = ST_RUN;
         end
         default: begin
            state_d = ST_OFF;
         end
      endcase
      if (state_q != ST_OFF) begin
         if (!mute_s_q || (|cause_d) || ctrl_q[`AMP_CTRL_SW_MUTE]) begin
            state_d = ST_MUTED;
         end
      end
      if (!pd_s_q) begin
         state_d = ST_OFF;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_OFF;
      end else if (ce) begin
         state_q <= state_d;
      end
   end

   // Soft turn-on ramp avoids a pop at unmute
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_q <= 8'h00;
         step_cnt_q <= 8'h00;
      end else if (ce) begin
         if (state_d != ST_RAMP && state_d != ST_RUN) begin
            level_q <= 8'h00;
            step_cnt_q <= 8'h00;
         end else if (step_cnt_q == STEP_CYC - 8'h01) begin
            step_cnt_q <= 8'h00;
            if (level_q != 8'hff) begin
               level_q <= level_q + 8'h01;
            end
         end else begin
            step_cnt_q <= step_cnt_q + 8'h01;
         end
      end
   end

   assign gain_code = ctrl_q[`AMP_CTRL_GAIN_OVR] ?
                      ctrl_q[`AMP_CTRL_GAIN_MSB:`AMP_CTRL_GAIN_LSB] :
                      {gain_select_msb, gain_select_lsb};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_enable <= 1'b0;
         stage_hiz <= 1'b1;
         soft_level <= 8'h00;
         gain_db <= 5'h00;
      end else if (ce) begin
         stage_enable <= (state_d == ST_RAMP) || (state_d == ST_RUN);
         stage_hiz <= (state_d == ST_OFF) || (|cause_d);
         soft_level <= level_q;
         gain_db <= gain_db_f(gain_code);
      end
   end

   // Modulators only step on master clock ticks
   assign run = (state_q == ST_RAMP) || (state_q == ST_RUN);

   pdm_channel u_left (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .step(mclk_tick),
      .run(run),
      .gain_code(gain_code),
      .level(level_q),
      .sample(sample_left),
      .out(out_left)
   );

   pdm_channel u_right (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .step(mclk_tick),
      .run(run),
      .gain_code(gain_code),
      .level(level_q),
      .sample(sample_right),
      .out(out_right)
   );

   // APB: one wait state so read data leaves a flip-flop
   assign access = psel & penable;
   assign done = access & pready;
   assign mapped = (paddr == `AMP_REG_CTRL) || (paddr == `AMP_REG_STATUS) ||
                   (paddr == `AMP_REG_IRQ_STAT) || (paddr == `AMP_REG_IRQ_MASK);
   assign rd_stat = done & ~pwrite & (paddr == `AMP_REG_IRQ_STAT);

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (paddr)
         `AMP_REG_CTRL: rd_mux = {28'h0, ctrl_q};
         `AMP_REG_STATUS: rd_mux = {8'h00, mute_s_q, pd_s_q, clk_lost, level_q,
                                    gain_db, state_q, |cause_q, cause_q,
                                    thermal_warning_n_oe};
         `AMP_REG_IRQ_STAT: rd_mux = {26'h0, irq_stat_q};
         `AMP_REG_IRQ_MASK: rd_mux = {26'h0, irq_mask_q};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= access & ~pready;
         if (access && !pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~mapped;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `AMP_CTRL_RESET;
         irq_mask_q <= `AMP_IRQ_MASK_RESET;
      end else if (ce && done && pwrite) begin
         if (paddr == `AMP_REG_CTRL) begin
            ctrl_q <= pwdata[3:0];
         end
         if (paddr == `AMP_REG_IRQ_MASK) begin
            irq_mask_q <= pwdata[5:0];
         end
      end
   end

   // Events: new cause bits, warning onset, mute-cycle clear
   always_comb begin
      irq_ev = 6'h00;
      irq_ev[`AMP_IRQ_WARN] = sense_q.temp_warn & pd_s_q & ~warn_prev_q;
      irq_ev[`AMP_IRQ_OVERTEMP] = cause_d[`AMP_CAUSE_OT] & ~cause_q[`AMP_CAUSE_OT];
      irq_ev[`AMP_IRQ_OVERCURRENT] = cause_d[`AMP_CAUSE_OC] & ~cause_q[`AMP_CAUSE_OC];
      irq_ev[`AMP_IRQ_UNDERVOLT] = cause_d[`AMP_CAUSE_UV] & ~cause_q[`AMP_CAUSE_UV];
      irq_ev[`AMP_IRQ_CLK_LOSS] = cause_d[`AMP_CAUSE_CL] & ~cause_q[`AMP_CAUSE_CL];
      irq_ev[`AMP_IRQ_CLEARED] = clear_evt & (|cause_q);
   end

   // Set beats the read-clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= 6'h00;
         irq <= 1'b0;
      end else if (ce) begin
         irq_stat_q <= (rd_stat ? 6'h00 : irq_stat_q) | irq_ev;
         irq <= |(((rd_stat ? 6'h00 : irq_stat_q) | irq_ev) & irq_mask_q);
      end
   end

endmodule

`default_nettype wire

// File: mcu_model.sv
// Controller-side model: drives control pins and clock, resolves flags
`timescale 1ns/1ps
`default_nettype none
module mcu_model (
   // Clock
   input wire logic pclk,
   // Bench requests
   input wire logic clk_run,
   input wire logic mute_req,
   input wire logic pd_req,
   input wire logic [1:0] gain_req,
   // Device flag drivers
   input wire logic fault_n_o,
   input wire logic fault_n_oe,
   input wire logic thermal_warning_n_o,
   input wire logic thermal_warning_n_oe,
   // Pins and wires
   output logic mute_n,
   output logic power_down_n,
   output logic gain_select_msb,
   output logic gain_select_lsb,
   output logic ext_clock_in,
   output logic fault_wire,
   output logic warn_wire
);
   logic [1:0] div_q = 2'h0;
   logic ext_q = 1'b0;
   // Pull-ups hold the wires high unless the device sinks them
   assign fault_wire = fault_n_oe ? fault_n_o : 1'b1;
   assign warn_wire = thermal_warning_n_oe ? thermal_warning_n_o : 1'b1;
   assign mute_n = mute_req;
   assign power_down_n = pd_req;
   assign gain_select_msb = gain_req[1];
   assign gain_select_lsb = gain_req[0];
   assign ext_clock_in = ext_q;
   // Half period of 4 pclk keeps edges visible; clock stands when stopped
   always_ff @(posedge pclk) begin
      if (clk_run) begin
         div_q <= div_q + 2'h1;
         if (div_q == 2'h3) begin
            ext_q <= !ext_q;
         end
      end
   end
endmodule
`default_nettype wire

// File: amp_fault_gain_control_properties.sv
// Port-level assertions for the amplifier control block
`timescale 1ns/1ps
`default_nettype none
module amp_checker (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Pins and sensors
   input wire logic mute_n,
   input wire logic power_down_n,
   input wire logic ext_clock_in,
   input wire amp_pkg::sense_s sense,
   // Flags and stage
   input wire logic fault_n_o,
   input wire logic fault_n_oe,
   input wire logic thermal_warning_n_o,
   input wire logic thermal_warning_n_oe,
   input wire logic master_clk,
   input wire logic stage_enable,
   input wire logic stage_hiz,
   input wire amp_pkg::diff_s out_left,
   input wire amp_pkg::diff_s out_right
);
   import amp_pkg::*;
   logic [7:0] run_hi_q, mute_lo_q, pd_lo_q;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Saturating run-length of a pin level; covers the synchroniser lag
   function automatic logic [7:0] run_f(input logic [7:0] c, input logic on);
      return !on ? 8'h00 : ((c == 8'hff) ? c : c + 8'h01);
   endfunction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) run_hi_q <= 8'h00;
      else run_hi_q <= run_f(run_hi_q, mute_n && power_down_n);
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) mute_lo_q <= 8'h00;
      else mute_lo_q <= run_f(mute_lo_q, !mute_n);
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pd_lo_q <= 8'h00;
      else pd_lo_q <= run_f(pd_lo_q, !power_down_n);
   end
   property p_ot; (ce && stage_enable && sense.temp_over) ##1 ce |-> ##1 fault_n_oe; endproperty
   a_ot: assert property (p_ot) else $error("overtemp not flagged");
   property p_oc; (ce && stage_enable && sense.over_current) ##1 ce |-> ##1 fault_n_oe; endproperty
   a_oc: assert property (p_oc) else $error("overcurrent not flagged");
   property p_uv; (ce && stage_enable && sense.pvdd_low) ##1 ce |-> ##1 fault_n_oe && stage_hiz;
   endproperty
   a_uv: assert property (p_uv) else $error("undervoltage not flagged");
   property p_warn; (ce && stage_enable && sense.temp_warn) ##1 ce |-> ##1 thermal_warning_n_oe;
   endproperty
   a_warn: assert property (p_warn) else $error("warning not flagged");
   property p_latch; (run_hi_q >= 8'd80 && fault_n_oe) |=> fault_n_oe; endproperty
   a_latch: assert property (p_latch) else $error("fault cleared without mute cycle");
   property p_od; (fault_n_oe |-> !fault_n_o) and (thermal_warning_n_oe |-> !thermal_warning_n_o);
   endproperty
   a_od: assert property (p_od) else $error("open-drain flag driven high");
   property p_div; $rose(ext_clock_in) |-> ##[1:6] $changed(master_clk); endproperty
   a_div: assert property (p_div) else $error("master clock missed an edge");
   property p_mute; mute_lo_q >= 8'd80 |-> !stage_enable; endproperty
   a_mute: assert property (p_mute) else $error("stage on while muted");
   property p_pd; pd_lo_q >= 8'd80 |-> stage_hiz && !stage_enable && out_left == '0
      && out_right == '0 && !fault_n_oe && !thermal_warning_n_oe; endproperty
   a_pd: assert property (p_pd) else $error("activity in power-down");
endmodule
bind amp_fault_gain_control amp_checker i_amp_checker (.pclk(pclk), .presetn(presetn),
   .ce(ce), .mute_n(mute_n), .power_down_n(power_down_n), .ext_clock_in(ext_clock_in),
   .sense(sense), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
   .thermal_warning_n_o(thermal_warning_n_o), .thermal_warning_n_oe(thermal_warning_n_oe),
   .master_clk(master_clk), .stage_enable(stage_enable), .stage_hiz(stage_hiz),
   .out_left(out_left), .out_right(out_right));
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the amplifier control and protection block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
   $display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end
`define WAITC(c) begin for (wk = 0; wk < 600 && !(c); wk++) @(posedge pclk); \
   if (!(c)) begin mismatches++; complete_run(); end end
module testbench;
   import amp_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, clk_run = 1'b0, mute_req = 1'b0, pd_req = 1'b0;
   logic [1:0] gain_req = 2'h0;
   sense_s sense = '0;
   logic mute_n, power_down_n, gs_msb, gs_lsb, ext_clk, fault_wire, warn_wire;
   logic f_o, f_oe, w_o, w_oe, master_clk, stage_enable, stage_hiz, irq;
   logic [4:0] gain_db;
   logic [7:0] soft_level;
   logic mclk_prev = 1'b1;
   diff_s out_left, out_right;
   logic [4:0] gexp [4] = '{5'h00, 5'h06, 5'h0c, 5'h12};
   int mismatches = 0, compares = 0, wk, n;
   always #4 pclk = ~pclk;
   amp_fault_gain_control i_amp_fault_gain_control (.pclk(pclk), .presetn(presetn), .ce(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .mute_n(mute_n),
      .power_down_n(power_down_n), .gain_select_msb(gs_msb), .gain_select_lsb(gs_lsb),
      .ext_clock_in(ext_clk), .sense(sense), .sample_left(16'sh1200),
      .sample_right(-16'sh0800), .fault_n_o(f_o), .fault_n_oe(f_oe),
      .thermal_warning_n_o(w_o), .thermal_warning_n_oe(w_oe), .master_clk(master_clk),
      .stage_enable(stage_enable), .stage_hiz(stage_hiz), .gain_db(gain_db),
      .soft_level(soft_level), .out_left(out_left), .out_right(out_right), .irq(irq));
   mcu_model i_mcu_model (.pclk(pclk), .clk_run(clk_run), .mute_req(mute_req),
      .pd_req(pd_req), .gain_req(gain_req), .fault_n_o(f_o), .fault_n_oe(f_oe),
      .thermal_warning_n_o(w_o), .thermal_warning_n_oe(w_oe), .mute_n(mute_n),
      .power_down_n(power_down_n), .gain_select_msb(gs_msb), .gain_select_lsb(gs_lsb),
      .ext_clock_in(ext_clk), .fault_wire(fault_wire), .warn_wire(warn_wire));
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge pclk);
   endtask
   // Outputs read right after an edge are the values sampled at it
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      `WAITC(pready === 1'b1)
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Idle edge so the next call never re-raises psel in this step
      @(posedge pclk);
   endtask
   task automatic mute_cycle();
      mute_req <= 1'b0;
      cyc(80);
      `CHK(stage_enable, 1'b0)
      mute_req <= 1'b1;
      `WAITC(stage_enable === 1'b1)
   endtask
   task automatic t_regs();
      apb(1'b0, 8'h00, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b0, 8'h0c, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b1, 8'h10, 32'hffff_ffff);
      `CHK(err, 1'b1)
      apb(1'b0, 8'h10, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      $display("Test regs done");
   endtask
   task automatic t_gain();
      for (int g = 0; g < 4; g++) begin
         gain_req <= g[1:0];
         cyc(2);
         `CHK(gain_db, gexp[g])
      end
      apb(1'b1, 8'h00, 32'h0000_000a);
      cyc(2);
      `CHK(gain_db, 5'h0c)
      apb(1'b1, 8'h00, 32'h0);
      $display("Test gain done");
   endtask
   task automatic t_master();
      `WAITC(master_clk === 1'b0)
      `WAITC(master_clk === 1'b1)
      n = 0;
      // Master period is 16 pclk, so a 312-cycle window holds 19 rises
      for (int k = 0; k < 312; k++) begin
         @(posedge pclk);
         if (master_clk === 1'b1 && mclk_prev === 1'b0) n++;
         mclk_prev = master_clk;
      end
      `CHK(n, 19)
      $display("Test master clock done");
   endtask
   task automatic t_warn();
      sense.temp_warn <= 1'b1;
      cyc(3);
      `CHK({warn_wire, fault_wire}, 2'b01)
      cyc(200);
      `CHK({stage_enable, stage_hiz}, 2'b10)
      `CHK({out_left.pos ^ out_left.neg, out_right.pos ^ out_right.neg}, 2'b11)
      sense.temp_warn <= 1'b0;
      cyc(3);
      `CHK(warn_wire, 1'b1)
      $display("Test warning done");
   endtask
   task automatic t_fault(input int s, input int q, input logic ei);
      sense[s] <= 1'b1;
      cyc(3);
      `CHK({fault_wire, stage_hiz, stage_enable}, 3'b010)
      `CHK(irq, ei)
      sense[s] <= 1'b0;
      cyc(150);
      `CHK(fault_wire, 1'b0)
      apb(1'b0, 8'h08, 32'h0);
      `CHK(rd[q], 1'b1)
      cyc(3);
      `CHK(irq, 1'b0)
      mute_cycle();
      `CHK(fault_wire, 1'b1)
      apb(1'b0, 8'h08, 32'h0);
      `CHK(rd[5], 1'b1)
      $display("Test fault done");
   endtask
   task automatic t_clk_loss();
      clk_run <= 1'b0;
      cyc(140);
      `CHK({fault_wire, stage_hiz}, 2'b01)
      clk_run <= 1'b1;
      mute_cycle();
      `CHK(fault_wire, 1'b1)
      $display("Test clock loss done");
   endtask
   task automatic t_pd();
      pd_req <= 1'b0;
      cyc(100);
      `CHK({stage_hiz, stage_enable}, 2'b10)
      `CHK({out_left, out_right}, 4'h0)
      sense.over_current <= 1'b1;
      cyc(10);
      `CHK(fault_wire, 1'b1)
      sense.over_current <= 1'b0;
      pd_req <= 1'b1;
      `WAITC(stage_enable === 1'b1)
      $display("Test power-down done");
   endtask
   initial begin
      cyc(8);
      presetn <= 1'b1;
      clk_run <= 1'b1;
      t_regs();
      pd_req <= 1'b1;
      mute_req <= 1'b1;
      `WAITC(stage_enable === 1'b1)
      `CHK(stage_hiz, 1'b0)
      `CHK(soft_level, 8'h00)
      // One ramp step per 125 cycles, so level 1 stands from 125 to 249
      cyc(130);
      `CHK(soft_level, 8'h01)
      t_gain();
      t_master();
      t_warn();
      t_fault(2, 1, 1'b0);
      apb(1'b1, 8'h0c, 32'h0000_003f);
      apb(1'b0, 8'h0c, 32'h0);
      `CHK(rd, 32'h0000_003f)
      t_fault(1, 2, 1'b1);
      t_fault(0, 3, 1'b1);
      t_clk_loss();
      t_pd();
      complete_run();
   end
endmodule
`default_nettype wire
